// File: shared/cic_pkg.sv
// Constants and types shared by the interrupt control block
package cic_pkg;
    localparam int NUM_SRC = 8;
    localparam int GRP_W = 4;
    localparam int VEC_W = 12;
    // Vector base; source i branches to base plus two times i
    localparam logic [11:0] VEC_BASE = 12'h100;
    localparam logic [11:0] VEC_STEP = 12'h002;
    localparam logic RST_FLAG = 1'b0;
    localparam logic RST_MASK = 1'b0;
    localparam logic RST_IE = 1'b0;

    typedef enum logic [2:0] {
        CIC_IDLE = 3'b001,
        CIC_WAIT = 3'b010,
        CIC_VECT = 3'b100
    } cic_state_t;
endpackage

// File: shared/cic_req_if.sv
// Request and vector carrier between the flag bank and the control core
`timescale 1ns/1ps
interface cic_req_if #(parameter int N = 8);
    logic [N-1:0] pend;
    logic any_pend;
    logic [$clog2(N)-1:0] top_idx;
    modport bank (output pend, output any_pend, output top_idx);
    modport core (input pend, input any_pend, input top_idx);
endinterface

// File: src/cic_prio.sv
// Fixed priority picker: highest index wins
`timescale 1ns/1ps
module cic_prio #(
    parameter int N = 8
) (
    input wire logic [N-1:0] flag, // Factor flags
    input wire logic [N-1:0] mask, // Mask bits
    cic_req_if.bank req // Pending summary out
);
    logic [N-1:0] pend;
    logic [$clog2(N)-1:0] idx;

    // A single source leaves no index to pick between
    if (N < 2) begin : g_bad_n
        $error("cic_prio: N must be at least 2");
    end

    // Flag AND mask per source
    assign pend = flag & mask;
    assign req.pend = pend;
    assign req.any_pend = |pend;
    assign req.top_idx = idx;

    // Scan upward so the highest pending index is kept
    always_comb begin
        idx = '0;
        for (int i = 0; i < N; i++) begin
            if (pend[i]) begin
                idx = ($clog2(N))'(i);
            end
        end
    end
endmodule

// File: src/cic_top.sv
// Interrupt factor flags, masks, enable state and vector issue
`timescale 1ns/1ps
module cic_top #(
    parameter int NUM_SRC = cic_pkg::NUM_SRC,
    parameter int GRP_W = cic_pkg::GRP_W
) (
    input wire logic clk_sys, // System clock
    input wire logic rst_b, // Async reset, active low
    input wire logic [NUM_SRC-1:0] src_event, // Source event pulses
    input wire logic [NUM_SRC-1:0] mask_wdata, // Mask write data
    input wire logic mask_we, // Mask write strobe
    output logic [NUM_SRC-1:0] mask_q, // Mask bits
    input wire logic grp_rd, // Read flag group strobe
    input wire logic [$clog2(NUM_SRC/GRP_W)-1:0] grp_sel, // Group index
    output logic [GRP_W-1:0] grp_rdata, // Flag group read data
    input wire logic set_ei, // Enter enabled state
    input wire logic set_di, // Enter disabled state
    output logic interrupts_enabled_state, // Enable flag
    output logic irq_req, // Request to the core
    input wire logic irq_ack, // Core accepts request
    input wire logic vec_fetch, // Core fetches vector
    output logic [cic_pkg::VEC_W-1:0] vec_addr_q, // Vector for PC
    output logic vec_valid // Vector valid, one-cycle pulse
);
    localparam int NGRP = NUM_SRC / GRP_W;
    localparam int SEL_W = $clog2(NGRP);

    // Groups must tile the sources and leave at least two groups
    if (NUM_SRC % GRP_W != 0 || NUM_SRC < 2 || NGRP < 2) begin : g_bad_cfg
        $error("cic_top: NUM_SRC must be a multiple of GRP_W");
    end

    logic [NUM_SRC-1:0] flag_q;
    logic [NUM_SRC-1:0] rd_clr;
    logic ie_q;
    logic [GRP_W-1:0] rdata_d;
    cic_pkg::cic_state_t state_q;
    cic_req_if #(.N(NUM_SRC)) req ();

    cic_prio #(.N(NUM_SRC)) u_prio (
        .flag(flag_q),
        .mask(mask_q),
        .req(req)
    );

    // Read clear covers the whole selected group at once
    generate
        for (genvar g = 0; g < NUM_SRC; g++) begin : g_clr
            assign rd_clr[g] = grp_rd && (grp_sel == SEL_W'(g / GRP_W));
        end
    endgenerate

    // Flags set regardless of mask; set beats a same-cycle read clear
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            flag_q <= {NUM_SRC{cic_pkg::RST_FLAG}};
        end else begin
            flag_q <= (flag_q & ~rd_clr) | src_event;
        end
    end

    // Mask register; only meaningful when written with interrupts off
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mask_q <= {NUM_SRC{cic_pkg::RST_MASK}};
        end else if (mask_we) begin
            mask_q <= mask_wdata;
        end
    end

    // Group read data returns flags before their clear
    always_comb begin
        rdata_d = '0;
        for (int i = 0; i < GRP_W; i++) begin
            rdata_d[i] = flag_q[grp_sel * GRP_W + i];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            grp_rdata <= '0;
        end else if (grp_rd) begin
            grp_rdata <= rdata_d;
        end
    end

    // Enable flag; acceptance wins over a same-cycle enable request
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ie_q <= cic_pkg::RST_IE;
        end else if (irq_req && irq_ack) begin
            ie_q <= 1'b0;
        end else if (set_di) begin
            ie_q <= 1'b0;
        end else if (set_ei) begin
            ie_q <= 1'b1;
        end
    end
    assign interrupts_enabled_state = ie_q;

    // Level request; a flag left set re-requests after enable
    assign irq_req = ie_q && req.any_pend;

    // Vector is chosen at fetch, not at accept, so a later higher source
    // can steer it; handlers must recheck their own flag
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= cic_pkg::CIC_IDLE;
            vec_addr_q <= '0;
        end else begin
            case (state_q)
                cic_pkg::CIC_IDLE: begin
                    if (irq_req && irq_ack) begin
                        state_q <= cic_pkg::CIC_WAIT;
                    end
                end
                cic_pkg::CIC_WAIT: begin
                    if (vec_fetch) begin
                        vec_addr_q <= cic_pkg::VEC_BASE + cic_pkg::VEC_STEP
                            * cic_pkg::VEC_W'(req.top_idx);
                        state_q <= cic_pkg::CIC_VECT;
                    end
                end
                cic_pkg::CIC_VECT: begin
                    state_q <= cic_pkg::CIC_IDLE;
                end
                default: begin
                    state_q <= cic_pkg::CIC_IDLE;
                end
            endcase
        end
    end
    assign vec_valid = (state_q == cic_pkg::CIC_VECT);

    property p_flag_set;
        @(posedge clk_sys) disable iff (!rst_b)
        src_event[0] |=> flag_q[0];
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("flag not set by event");

    property p_accept_di;
        @(posedge clk_sys) disable iff (!rst_b)
        irq_req && irq_ack |=> !interrupts_enabled_state;
    endproperty
    a_accept_di: assert property (p_accept_di)
        else $error("enable not dropped on accept");

    property p_nest;
        @(posedge clk_sys) disable iff (!rst_b)
        set_ei && !set_di && !(irq_req && irq_ack) |=> ie_q;
    endproperty
    a_nest: assert property (p_nest)
        else $error("enable not taken");

    property p_rereq;
        @(posedge clk_sys) disable iff (!rst_b)
        set_ei && !set_di && !irq_ack && !grp_rd && !mask_we
            && (|(flag_q & mask_q)) |=> irq_req;
    endproperty
    a_rereq: assert property (p_rereq)
        else $error("pending flag not requested");

    property p_rdclr;
        @(posedge clk_sys) disable iff (!rst_b)
        grp_rd && grp_sel == '0 && src_event[0] == 1'b0 |=> !flag_q[0];
    endproperty
    a_rdclr: assert property (p_rdclr)
        else $error("flag not cleared by read");

    property p_grpclr;
        @(posedge clk_sys) disable iff (!rst_b)
        grp_rd && grp_sel == '0 && src_event[GRP_W-1:0] == '0
            |=> flag_q[GRP_W-1:0] == '0;
    endproperty
    a_grpclr: assert property (p_grpclr)
        else $error("group not cleared by read");

    property p_prio;
        @(posedge clk_sys) disable iff (!rst_b)
        state_q == cic_pkg::CIC_WAIT && vec_fetch && req.pend[NUM_SRC-1]
            |=> vec_addr_q == cic_pkg::VEC_BASE + cic_pkg::VEC_STEP
                * cic_pkg::VEC_W'(NUM_SRC - 1);
    endproperty
    a_prio: assert property (p_prio)
        else $error("top source vector not chosen");

    property p_hold;
        @(posedge clk_sys) disable iff (!rst_b)
        flag_q[1] && !grp_rd |=> flag_q[1];
    endproperty
    a_hold: assert property (p_hold)
        else $error("flag dropped without read");

    property p_mask_free;
        @(posedge clk_sys) disable iff (!rst_b)
        src_event[NUM_SRC-1] && !mask_q[NUM_SRC-1] |=> flag_q[NUM_SRC-1];
    endproperty
    a_mask_free: assert property (p_mask_free)
        else $error("masked source flag not set");

    property p_di_hold;
        @(posedge clk_sys) disable iff (!rst_b)
        !interrupts_enabled_state && !set_ei |=> !interrupts_enabled_state;
    endproperty
    a_di_hold: assert property (p_di_hold)
        else $error("enable rose without software");

    property p_rd_data;
        @(posedge clk_sys) disable iff (!rst_b)
        grp_rd && grp_sel == '0 |=> grp_rdata == $past(flag_q[GRP_W-1:0]);
    endproperty
    a_rd_data: assert property (p_rd_data)
        else $error("read data not the flags before clear");

    property p_vec_pulse;
        @(posedge clk_sys) disable iff (!rst_b)
        vec_valid |=> !vec_valid;
    endproperty
    a_vec_pulse: assert property (p_vec_pulse)
        else $error("vector valid held too long");

    property p_accept_wait;
        @(posedge clk_sys) disable iff (!rst_b)
        state_q == cic_pkg::CIC_IDLE && irq_req && irq_ack
            |=> state_q == cic_pkg::CIC_WAIT;
    endproperty
    a_accept_wait: assert property (p_accept_wait)
        else $error("accept did not wait for the fetch");
endmodule

// File: bench/cic_core_model.sv
// Behavioural CPU core that accepts requests and fetches vectors
`timescale 1ns/1ps
module cic_core_model (
    input wire logic clk_sys, // System clock
    input wire logic rst_b, // Async reset, active low
    input wire logic irq_req, // Request from the block
    input wire logic vec_valid, // Vector loaded
    input wire logic slow, // Delay the vector fetch
    output logic irq_ack, // Accept pulse
    output logic vec_fetch // Vector fetch pulse
);
    logic busy_q;
    logic [2:0] wait_q;

    // Accept at once; a busy core never accepts twice before its fetch
    assign irq_ack = irq_req & ~busy_q;

    // One fetch per accept, late by three cycles when slow
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            busy_q <= 1'b0;
            wait_q <= 3'h0;
            vec_fetch <= 1'b0;
        end else begin
            vec_fetch <= 1'b0;
            if (irq_ack) begin
                busy_q <= 1'b1;
                wait_q <= slow ? 3'h3 : 3'h0;
                vec_fetch <= ~slow;
            end else if (busy_q && wait_q != 3'h0) begin
                wait_q <= wait_q - 3'h1;
                vec_fetch <= (wait_q == 3'h1);
            end
            if (vec_valid) begin
                busy_q <= 1'b0;
            end
        end
    end
endmodule

// File: bench/testbench.sv
// Self-checking bench for the interrupt control block
`timescale 1ns/1ps
module testbench;
    logic clk_sys, rst_b, mask_we, grp_rd, grp_sel, set_ei, set_di;
    logic irq_ack, vec_fetch, slow, irq_req, vec_valid, ie;
    logic [7:0] src_event, mask_wdata, mask_q;
    logic [3:0] grp_rdata;
    logic [11:0] vec_addr_q;
    int error_cnt = 0;
    int n_compared = 0;
    // Strobe sets: {mask_we, grp_rd, grp_sel, set_ei, set_di}
    localparam logic [4:0] MW = 5'h10;
    localparam logic [4:0] RD0 = 5'h08;
    localparam logic [4:0] RD1 = 5'h0c;
    localparam logic [4:0] C_EN = 5'h02;
    localparam logic [4:0] C_DIS = 5'h01;

    cic_top i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .src_event(src_event), .mask_wdata(mask_wdata),
        .mask_we(mask_we), .mask_q(mask_q), .grp_rd(grp_rd),
        .grp_sel(grp_sel), .grp_rdata(grp_rdata), .set_ei(set_ei),
        .set_di(set_di), .interrupts_enabled_state(ie),
        .irq_req(irq_req), .irq_ack(irq_ack), .vec_fetch(vec_fetch),
        .vec_addr_q(vec_addr_q), .vec_valid(vec_valid));
    cic_core_model i_core (.clk_sys(clk_sys), .rst_b(rst_b),
        .irq_req(irq_req), .vec_valid(vec_valid), .slow(slow),
        .irq_ack(irq_ack), .vec_fetch(vec_fetch));

    // System clock, 10 ns period
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // One cycle of strobes after an idle one, so that no strobe is
    // lowered and raised again in the same time step
    task automatic cyc(input logic [7:0] ev, input logic [7:0] md,
        input logic [4:0] ctl);
        @(posedge clk_sys);
        #1;
        {mask_we, grp_rd, grp_sel, set_ei, set_di} = ctl;
        src_event = ev;
        mask_wdata = md;
        @(posedge clk_sys);
        #1;
        {mask_we, grp_rd, grp_sel, set_ei, set_di} = 5'h00;
        src_event = 8'h00;
    endtask

    // Bounded wait for the loaded vector
    task automatic wait_vec;
        for (int i = 0; i < 20 && vec_valid !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        chk(vec_valid, 12'h001);
    endtask

    task automatic t_flags;
        cyc(8'h0e, 8'h00, 5'h00);
        cyc(8'h00, 8'h00, RD0);
        chk(grp_rdata, 12'h00e);
        cyc(8'h00, 8'h00, RD0);
        chk(grp_rdata, 12'h000);
        cyc(8'h00, 8'h00, C_EN);
        cyc(8'h80, 8'h00, 5'h00);
        chk(irq_req, 12'h000);
        cyc(8'h00, 8'h00, C_DIS);
        cyc(8'h00, 8'h00, RD1);
        chk(grp_rdata, 12'h008);
        $display("t_flags done");
    endtask

    task automatic t_prio;
        cyc(8'h00, 8'hff, MW);
        chk(mask_q, 12'h0ff);
        cyc(8'h24, 8'h00, 5'h00);
        chk(irq_req, 12'h000);
        cyc(8'h00, 8'h00, C_EN);
        wait_vec();
        chk(vec_addr_q, 12'h10a);
        chk(ie, 12'h000);
        slow = 1'b1;
        cyc(8'h00, 8'h00, C_EN);
        wait_vec();
        chk(vec_addr_q, 12'h10a);
        slow = 1'b0;
        cyc(8'h00, 8'h00, RD1);
        chk(grp_rdata, 12'h002);
        cyc(8'h00, 8'h00, C_EN);
        wait_vec();
        chk(vec_addr_q, 12'h104);
        cyc(8'h00, 8'h00, RD0);
        chk(grp_rdata, 12'h004);
        cyc(8'h00, 8'h00, C_EN);
        chk(ie, 12'h001);
        chk(irq_req, 12'h000);
        cyc(8'h00, 8'h00, C_DIS);
        $display("t_prio done");
    endtask

    // Higher source arriving before a late fetch steers the vector
    task automatic t_steer;
        cyc(8'h04, 8'h00, 5'h00);
        slow = 1'b1;
        cyc(8'h00, 8'h00, C_EN);
        cyc(8'h80, 8'h00, 5'h00);
        wait_vec();
        chk(vec_addr_q, 12'h10e);
        slow = 1'b0;
        cyc(8'h00, 8'h00, RD1);
        chk(grp_rdata, 12'h008);
        cyc(8'h00, 8'h00, C_EN);
        wait_vec();
        chk(vec_addr_q, 12'h104);
        cyc(8'h00, 8'h00, RD0);
        chk(grp_rdata, 12'h004);
        cyc(8'h00, 8'h00, C_EN);
        chk(irq_req, 12'h000);
        cyc(8'h00, 8'h00, C_DIS);
        $display("t_steer done");
    endtask

    // Mid-run reset returns every output to its idle value
    task automatic t_reset;
        cyc(8'h81, 8'h3c, MW);
        rst_b = 1'b0;
        @(posedge clk_sys);
        #1;
        chk(mask_q, 12'h000);
        chk(ie, 12'h000);
        chk(irq_req, 12'h000);
        chk(vec_valid, 12'h000);
        chk(vec_addr_q, 12'h000);
        chk(grp_rdata, 12'h000);
        rst_b = 1'b1;
        cyc(8'h00, 8'h00, RD1);
        chk(grp_rdata, 12'h000);
        cyc(8'h00, 8'h00, RD0);
        chk(grp_rdata, 12'h000);
        $display("t_reset done");
    endtask

    task automatic stop_test;
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Main sequence after a 12-cycle reset
    initial begin
        rst_b = 1'b0;
        slow = 1'b0;
        src_event = 8'h00;
        mask_wdata = 8'h00;
        {mask_we, grp_rd, grp_sel, set_ei, set_di} = 5'h00;
        repeat (12) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        t_flags();
        t_prio();
        t_steer();
        t_reset();
        stop_test();
    end

    // Watchdog, far beyond the fewer than one hundred cycles the tests need
    initial begin
        #20000;
        error_cnt++;
        stop_test();
    end
endmodule
